// ---- fspa_pkg.sv ----
/*
  Package for the flash sector access and protection block: register
  offsets, field positions, reset values, sector map, link command bytes and sequencer states.
  Assumes a 16-bit CPU address space and an 8-bit flash array.
*/
package fspa_pkg;
  // Avalon-MM word byte addresses
  localparam logic [3:0] ADDR_FLASH_CTRL_STAT = 4'h0;
  localparam logic [3:0] ADDR_GUARD_KEY = 4'h4;
  localparam logic [3:0] ADDR_ADDR_LO = 4'h8;
  localparam logic [3:0] ADDR_ADDR_HI = 4'hC;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  // Control/status fields
  localparam int FCS_START_BIT = 0;
  localparam int FCS_ERASE_BIT = 1;
  localparam int FCS_ALL_BIT = 2;
  localparam int FCS_OPT_BIT = 3;
  localparam int FCS_ARMED_BIT = 4;
  localparam int FCS_REJ_BIT = 5;
  localparam int FCS_PROT_BIT = 6;
  localparam int FCS_PGM_BIT = 7;
  localparam logic [7:0] FLASH_CTRL_STAT_RST = 8'h00;
  // Two-step guard keys
  localparam logic [7:0] GUARD_KEY1 = 8'h56;
  localparam logic [7:0] GUARD_KEY2 = 8'hAE;
  // Sector map: sector 0 F000-FFFF, sector 1 E000-EFFF, rest sector 2
  localparam logic [3:0] SECT0_TOP = 4'hF;
  localparam logic [3:0] SECT1_TOP = 4'hE;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam int OPT_PROT_BIT = 0;
  // Serial link command bytes
  localparam logic [7:0] LINK_ENTER = 8'hA5;
  localparam logic [7:0] LINK_EXIT = 8'h5A;
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_ERASE = 2'b01,
    FS_PROG = 2'b10
  } fspa_state_e;
endpackage

// ---- fspa_core.sv ----
/*
  Flash sector access and protection: byte program, sector and whole
  erase, protection, option byte and serial in-circuit link entry.
  Assumes an Avalon-MM master on clock and a serial link clocked far
  slower than clock; the array is a small flip-flop model.
*/
// Operation
// - Erasing one sector leaves every other sector unchanged.
// - Programming is per byte; erase whole array or one sector.
// - Three user sectors, each erased on its own.
// - Sectors 0 and 1 are 4 Kbytes at the top of memory.
// - Sector 0 spans F000h to FFFFh, holding the vectors.
// - Tool or in-circuit mode may change every sector and options.
// - Application mode may change all sectors except sector 0.
// - Active protection blocks reading and rewriting program memory.
// - Protection applies in test and in-circuit programming modes.
// - Removing protection first erases the whole program memory.
// - Option bit zero low enables protection, high disables it.
// - Option bytes are unmapped and reached only in programming mode.
// - Blank flash and option bytes read FFh.
// - Control/status register resets to 00h.
// - Controller requests in-circuit mode; device enters it.
// - Link uses one serial clock pin and one serial data pin.
// - With a tool attached, link pins are withheld from application.
// - In-circuit test downloads patterns to RAM and runs them.
// - A register access guard prevents accidental program or erase.
// - Software trap is reserved while in-circuit mode is active.
`timescale 1ns/1ps
module fspa_core
  import fspa_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int ARRAY_W = 6
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic toolInserted,
  input wire logic toolAttached,
  input wire logic serialLinkClockPin,
  input wire logic serialLinkDataPin,
  input wire logic [ADDR_W-1:0] cpuAddr,
  input wire logic cpuRead,
  output logic [7:0] cpuData,
  output logic inCircuitCommMode,
  output logic inCircuitTest,
  output logic trapReserved,
  output logic linkPinsOwned,
  output logic readoutProtect
);
  // Array model: low ARRAY_W address bits index each sector
  localparam int DEPTH = 1 << ARRAY_W;
  logic [7:0] mem0 [DEPTH];
  logic [7:0] mem1 [DEPTH];
  logic [7:0] mem2 [DEPTH];
  logic [7:0] option_q;
  logic [7:0] fcs_q;
  logic [7:0] dataReg_q;
  logic [15:0] tgtAddr_q;
  logic [1:0] guard_q;
  fspa_state_e state_q;
  logic [ARRAY_W:0] eraseIdx_q;
  logic [1:0] eraseSel_q;
  logic eraseAll_q;
  logic icc_q;

  // Two-stage synchronisers for pins from the link side
  logic [1:0] clkSync_q;
  logic [1:0] datSync_q;
  logic [1:0] toolSync_q;
  logic [1:0] attSync_q;
  logic clkPrev_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      {clkSync_q, datSync_q, toolSync_q, attSync_q} <= 8'h00;
      clkPrev_q <= 1'b0;
    end else begin
      clkSync_q <= {clkSync_q[0], serialLinkClockPin};
      datSync_q <= {datSync_q[0], serialLinkDataPin};
      toolSync_q <= {toolSync_q[0], toolInserted};
      attSync_q <= {attSync_q[0], toolAttached};
      clkPrev_q <= clkSync_q[1];
    end
  end
  wire linkRise = clkSync_q[1] & ~clkPrev_q;

  // Serial shifter: data sampled on link clock rising edge
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      {shift_q, bitCnt_q, icc_q} <= 12'h000;
    end else if (linkRise) begin
      shift_q <= {shift_q[6:0], datSync_q[1]};
      bitCnt_q <= bitCnt_q + 3'h1;
      if (bitCnt_q == 3'h7) begin
        // Controller's byte switches the mode on or off
        if ({shift_q[6:0], datSync_q[1]} == LINK_ENTER)
          icc_q <= 1'b1;
        else if ({shift_q[6:0], datSync_q[1]} == LINK_EXIT)
          icc_q <= 1'b0;
      end
    end
  end

  // Programming mode: tool insertion or in-circuit session
  wire pgmMode = toolSync_q[1] | icc_q;
  // Option bit zero low means protected
  wire protOn = ~option_q[OPT_PROT_BIT];

  // Sector decode from the top address nibble
  function automatic logic [1:0] sectorOf(input logic [15:0] a);
    sectorOf = (a[15:12] == SECT0_TOP) ? 2'd0 :
      (a[15:12] == SECT1_TOP) ? 2'd1 : 2'd2;
  endfunction

  // Bus access decode
  wire acc = read | write;
  wire wrEn = write & ~waitrequest;
  wire [1:0] tgtSect = sectorOf(tgtAddr_q);
  wire [ARRAY_W-1:0] tgtIdx = tgtAddr_q[ARRAY_W-1:0];
  wire startReq = wrEn && address == ADDR_FLASH_CTRL_STAT &&
    writedata[FCS_START_BIT];
  // Guard must be armed with two keys first
  wire armed = guard_q == 2'd2;
  // Sector 0 locked outside programming mode
  wire sectLock = ~pgmMode && tgtSect == 2'd0;
  // Protection blocks rewriting in programming mode
  wire optOp = writedata[FCS_OPT_BIT];
  wire unprotect = optOp && pgmMode && protOn &&
    dataReg_q[OPT_PROT_BIT];
  wire rej = ~armed || state_q != FS_IDLE ||
    (optOp && ~pgmMode) ||
    (~optOp && protOn && pgmMode) ||
    (~optOp && ~writedata[FCS_ALL_BIT] && sectLock) ||
    (~optOp && writedata[FCS_ALL_BIT] && ~pgmMode);
  wire goOp = startReq && ~rej;

  // Bus handshake: one wait cycle, then low for one cycle; kept in a
  // flop so the master never sees a decode glitch
  always_ff @(posedge clock) begin
    if (srst)
      waitrequest <= 1'b1;
    else
      waitrequest <= ~(acc & waitrequest);
  end

  // Read data latched as the answer is granted, low byte only
  always_ff @(posedge clock) begin
    if (srst)
      readdata <= 32'h0000_0000;
    else if (acc && waitrequest) begin
      unique case (address)
        ADDR_FLASH_CTRL_STAT: readdata <= {24'h00_0000, fcs_q};
        ADDR_GUARD_KEY: readdata <= {30'h0000_0000, guard_q};
        ADDR_ADDR_LO: readdata <= {24'h00_0000, tgtAddr_q[7:0]};
        ADDR_ADDR_HI: readdata <= {24'h00_0000, tgtAddr_q[15:8]};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Target address and data byte; option byte offered in pgm mode only
  always_ff @(posedge clock) begin
    if (srst) begin
      tgtAddr_q <= 16'h0000;
      dataReg_q <= 8'h00;
    end else if (wrEn && address == ADDR_ADDR_LO) begin
      tgtAddr_q[7:0] <= writedata[7:0];
      dataReg_q <= writedata[15:8];
    end else if (wrEn && address == ADDR_ADDR_HI)
      tgtAddr_q[15:8] <= writedata[7:0];
  end

  // Guard arming: key1 then key2; any start or any other key register write disarms
  always_ff @(posedge clock) begin
    if (srst)
      guard_q <= 2'd0;
    else if (wrEn && address == ADDR_GUARD_KEY) begin
      if (guard_q == 2'd0 && writedata[7:0] == GUARD_KEY1)
        guard_q <= 2'd1;
      else if (guard_q == 2'd1 && writedata[7:0] == GUARD_KEY2)
        guard_q <= 2'd2;
      else
        guard_q <= 2'd0;
    end else if (startReq)
      guard_q <= 2'd0;
  end

  // Control/status register
  always_ff @(posedge clock) begin
    if (srst)
      fcs_q <= FLASH_CTRL_STAT_RST;
    else begin
      if (startReq) begin
        fcs_q[FCS_ERASE_BIT] <= writedata[FCS_ERASE_BIT];
        fcs_q[FCS_ALL_BIT] <= writedata[FCS_ALL_BIT];
        fcs_q[FCS_OPT_BIT] <= writedata[FCS_OPT_BIT];
        fcs_q[FCS_REJ_BIT] <= rej;
      end
      fcs_q[FCS_START_BIT] <= goOp | (state_q != FS_IDLE &&
        !(state_q == FS_ERASE && eraseIdx_q[ARRAY_W] &&
        !fcs_q[FCS_OPT_BIT]));
      fcs_q[FCS_ARMED_BIT] <= armed;
      fcs_q[FCS_PROT_BIT] <= protOn;
      fcs_q[FCS_PGM_BIT] <= pgmMode;
    end
  end

  // Operation sequencer: program a byte, or walk erase over a sector
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= FS_IDLE;
      eraseIdx_q <= '0;
      eraseSel_q <= 2'd0;
      eraseAll_q <= 1'b0;
    end else begin
      unique case (state_q)
        FS_IDLE: if (goOp) begin
          eraseIdx_q <= '0;
          eraseSel_q <= tgtSect;
          // Unprotecting erases everything first
          eraseAll_q <= writedata[FCS_ALL_BIT] | unprotect;
          if (writedata[FCS_ERASE_BIT] | unprotect)
            state_q <= FS_ERASE;
          else
            state_q <= FS_PROG;
        end
        FS_PROG: state_q <= FS_IDLE;
        FS_ERASE: begin
          eraseIdx_q <= eraseIdx_q + 1'b1;
          // An unprotect erase goes on to write the option byte
          if (eraseIdx_q[ARRAY_W])
            state_q <= fcs_q[FCS_OPT_BIT] ? FS_PROG : FS_IDLE;
        end
        default: state_q <= FS_IDLE;
      endcase
    end
  end
  wire erasing = state_q == FS_ERASE && !eraseIdx_q[ARRAY_W];
  wire optWrite = state_q == FS_PROG && fcs_q[FCS_OPT_BIT];
  wire [ARRAY_W-1:0] eIdx = eraseIdx_q[ARRAY_W-1:0];

  // Array update: the selected sector changes, or every sector on a whole erase
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem0[i] <= ERASED_BYTE;
        mem1[i] <= ERASED_BYTE;
        mem2[i] <= ERASED_BYTE;
      end
    end else if (erasing) begin
      if (eraseAll_q || eraseSel_q == 2'd0)
        mem0[eIdx] <= ERASED_BYTE;
      if (eraseAll_q || eraseSel_q == 2'd1)
        mem1[eIdx] <= ERASED_BYTE;
      if (eraseAll_q || eraseSel_q == 2'd2)
        mem2[eIdx] <= ERASED_BYTE;
    end else if (state_q == FS_PROG && !fcs_q[FCS_OPT_BIT]) begin
      // Flash programming only clears bits
      unique case (tgtSect)
        2'd0: mem0[tgtIdx] <= mem0[tgtIdx] & dataReg_q;
        2'd1: mem1[tgtIdx] <= mem1[tgtIdx] & dataReg_q;
        default: mem2[tgtIdx] <= mem2[tgtIdx] & dataReg_q;
      endcase
    end
  end

  // Option byte, written directly, or after a full erase when unprotecting
  always_ff @(posedge clock) begin
    if (srst)
      option_q <= OPTION_RST;
    else if (optWrite)
      option_q <= dataReg_q;
  end

  // CPU read port; protected array reads FFh in programming mode
  always_ff @(posedge clock) begin
    if (srst)
      cpuData <= ERASED_BYTE;
    else if (cpuRead && protOn && pgmMode)
      cpuData <= ERASED_BYTE;
    else if (cpuRead)
      unique case (sectorOf(cpuAddr[15:0]))
        2'd0: cpuData <= mem0[cpuAddr[ARRAY_W-1:0]];
        2'd1: cpuData <= mem1[cpuAddr[ARRAY_W-1:0]];
        default: cpuData <= mem2[cpuAddr[ARRAY_W-1:0]];
      endcase
  end

  // Mode flags seen by the rest of the chip
  always_ff @(posedge clock) begin
    if (srst) begin
      {inCircuitTest, inCircuitCommMode, trapReserved} <= 3'h0;
      {linkPinsOwned, readoutProtect} <= 2'h0;
    end else begin
      // Test runs from RAM only inside a session
      inCircuitTest <= icc_q & ~protOn;
      inCircuitCommMode <= icc_q;
      trapReserved <= icc_q;
      linkPinsOwned <= attSync_q[1] | icc_q;
      readoutProtect <= protOn;
    end
  end
  // Checks
  property p_guard;
    @(posedge clock) disable iff (srst)
    (startReq && guard_q != 2'd2) |=> fcs_q[FCS_REJ_BIT] &&
      (state_q == FS_IDLE || $past(state_q) != FS_IDLE);
  endproperty
  a_guard: assert property (p_guard)
    else $error("start accepted without guard");
  property p_sect0;
    @(posedge clock) disable iff (srst)
    (state_q == FS_PROG && !pgmMode) |-> tgtSect != 2'd0;
  endproperty
  a_sect0: assert property (p_sect0)
    else $error("sector 0 programmed in application mode");
  property p_prot_read;
    @(posedge clock) disable iff (srst)
    (cpuRead && protOn && pgmMode) |=> cpuData == ERASED_BYTE;
  endproperty
  a_prot_read: assert property (p_prot_read)
    else $error("protected read leaked data");
  property p_opt_mode;
    @(posedge clock) disable iff (srst)
    optWrite |-> $past(pgmMode);
  endproperty
  a_opt_mode: assert property (p_opt_mode)
    else $error("option written outside programming mode");
  property p_erase_len;
    @(posedge clock) disable iff (srst)
    (state_q == FS_IDLE && goOp && !unprotect && writedata[FCS_ERASE_BIT])
      |=> erasing [*8];
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase walk shorter than expected");
  property p_trap;
    @(posedge clock) disable iff (srst)
    $rose(icc_q) |=> trapReserved;
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap not reserved in session");
  property p_pins;
    @(posedge clock) disable iff (srst)
    attSync_q[1] |=> linkPinsOwned;
  endproperty
  a_pins: assert property (p_pins)
    else $error("link pins not withheld");
  property p_unprot;
    @(posedge clock) disable iff (srst)
    (goOp && unprotect) |=> state_q == FS_ERASE && eraseAll_q;
  endproperty
  a_unprot: assert property (p_unprot)
    else $error("unprotect without full erase");
endmodule

// ---- fspa_tool_model.sv ----
/*
  Model of the programming tool on the serial link.
  Assumes the block samples the link clock with its own clock.
*/
`timescale 1ns/1ps
module fspa_tool_model #(
  parameter int HALF_NS = 200
) (
  output logic linkClk,
  output logic linkData
);
  // Clock stands low between frames; it only runs inside a frame
  initial begin
    linkClk = 1'b0;
    linkData = 1'b0;
  end
  // One clock pin, one data pin, MSB first, data moves while low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      linkData = b[i];
      #(HALF_NS) linkClk = 1'b1;
      #(HALF_NS) linkClk = 1'b0;
    end
    // Released line flips so a stale bit cannot pass for data
    #(HALF_NS) linkData = ~b[0];
  endtask
endmodule

// ---- test_fspa_core.sv ----
/*
  Self-checking bench for fspa_core: register bus, sector map,
  guard, option byte protection and link session entry.
  Assumes the tool model drives the link pins.
*/
`timescale 1ns/1ps
module test_fspa_core
  import fspa_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic toolInserted = 1'b0;
  logic toolAttached = 1'b0;
  logic linkClk;
  logic linkData;
  logic [15:0] cpuAddr = 16'h0;
  logic cpuRead = 1'b0;
  logic [7:0] cpuData;
  logic comm, icTest, trap, owned, prot;
  logic [3:0] lvl;
  logic [7:0] st;
  logic [31:0] q;
  int failures = 0;
  int checkCount = 0;
  // Level outputs except icTest gathered so one wait task serves them all
  assign lvl = {comm, trap, owned, prot};
  // 20 MHz clock
  always #25 clock = ~clock;
  fspa_tool_model tool (.linkClk(linkClk), .linkData(linkData));
  fspa_core #(.ADDR_W(16), .ARRAY_W(6)) dut (
    .clock(clock), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .toolInserted(toolInserted),
    .toolAttached(toolAttached), .serialLinkClockPin(linkClk),
    .serialLinkDataPin(linkData), .cpuAddr(cpuAddr), .cpuRead(cpuRead),
    .cpuData(cpuData), .inCircuitCommMode(comm), .inCircuitTest(icTest),
    .trapReserved(trap), .linkPinsOwned(owned), .readoutProtect(prot));
  task automatic conclude();
    $display("checks=%0d failures=%0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    checkCount++;
    if (a !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  // Avalon cycle held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    r = readdata;
    if (n >= 40) failures++;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask
  // CPU byte read, result settles one cycle after the request
  task automatic cpu(input logic [15:0] a, input logic [7:0] e);
    cpuAddr <= a;
    cpuRead <= 1'b1;
    @(posedge clock);
    cpuRead <= 1'b0;
    @(negedge clock);
    chk({24'h0, e}, {24'h0, cpuData});
    @(posedge clock);
  endtask
  // Address and data first, keys right before start, then poll busy
  task automatic op(input logic [15:0] a, input logic [7:0] d,
      input logic [7:0] ctl, input logic keyed);
    int n;
    bus(1'b1, ADDR_ADDR_LO, {16'h0, d, a[7:0]}, q);
    bus(1'b1, ADDR_ADDR_HI, {24'h0, a[15:8]}, q);
    if (keyed) begin
      bus(1'b1, ADDR_GUARD_KEY, {24'h0, GUARD_KEY1}, q);
      bus(1'b1, ADDR_GUARD_KEY, {24'h0, GUARD_KEY2}, q);
    end
    bus(1'b1, ADDR_FLASH_CTRL_STAT, {24'h0, ctl}, q);
    n = 0;
    do begin
      bus(1'b0, ADDR_FLASH_CTRL_STAT, 32'h0, q);
      n++;
    end while (q[FCS_START_BIT] !== 1'b0 && n < 100);
    st = q[7:0];
  endtask
  // Levels are looked at on the falling edge, where they stand settled
  task automatic waitlvl(input logic [3:0] m, input logic [3:0] v);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((lvl & m) !== v && n < 40);
    chk({28'h0, v}, {28'h0, lvl & m});
    @(posedge clock);
  endtask
  // Programming mode flag polled through the status register
  task automatic pgm(input logic e);
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_FLASH_CTRL_STAT, 32'h0, q);
      n++;
    end while (q[FCS_PGM_BIT] !== e && n < 20);
    chk({31'h0, e}, {31'h0, q[FCS_PGM_BIT]});
  endtask
  task automatic t_reset();
    bus(1'b0, ADDR_FLASH_CTRL_STAT, 32'h0, q);
    chk({24'h0, FLASH_CTRL_STAT_RST}, q);
    bus(1'b0, 4'h2, 32'h0, q);
    chk(32'h0, q);
    cpu(16'hF000, ERASED_BYTE);
    waitlvl(4'hF, 4'h0);
    chk(32'h0, {31'h0, icTest});
    $display("test reset done");
  endtask
  task automatic t_app();
    op(16'hE010, 8'h3C, 8'h01, 1'b1);
    cpu(16'hE010, 8'h3C);
    op(16'hD020, 8'hA5, 8'h01, 1'b1);
    cpu(16'hD020, 8'hA5);
    op(16'hF000, 8'h00, 8'h01, 1'b1);
    chk(32'h1, {31'h0, st[FCS_REJ_BIT]});
    cpu(16'hF000, ERASED_BYTE);
    op(16'hE010, 8'h00, 8'h07, 1'b1);
    chk(32'h1, {31'h0, st[FCS_REJ_BIT]});
    cpu(16'hE010, 8'h3C);
    op(16'hE011, 8'h00, 8'h01, 1'b0);
    chk(32'h1, {31'h0, st[FCS_REJ_BIT]});
    cpu(16'hE011, ERASED_BYTE);
    op(16'h0000, 8'hFE, 8'h09, 1'b1);
    chk(32'h1, {31'h0, st[FCS_REJ_BIT]});
    waitlvl(4'h1, 4'h0);
    $display("test application mode done");
  endtask
  task automatic t_tool();
    toolInserted <= 1'b1;
    pgm(1'b1);
    op(16'hF000, 8'h12, 8'h01, 1'b1);
    op(16'hEFFF, 8'h34, 8'h01, 1'b1);
    op(16'hE000, 8'h00, 8'h03, 1'b1);
    cpu(16'hEFFF, ERASED_BYTE);
    cpu(16'hE010, ERASED_BYTE);
    cpu(16'hF000, 8'h12);
    cpu(16'hD020, 8'hA5);
    $display("test tool mode done");
  endtask
  task automatic t_prot();
    op(16'h0000, 8'hFE, 8'h09, 1'b1);
    waitlvl(4'h1, 4'h1);
    bus(1'b0, ADDR_FLASH_CTRL_STAT, 32'h0, q);
    chk(32'h1, {31'h0, q[FCS_PROT_BIT]});
    op(16'hE020, 8'h55, 8'h01, 1'b1);
    chk(32'h1, {31'h0, st[FCS_REJ_BIT]});
    op(16'h0000, 8'hFF, 8'h09, 1'b1);
    waitlvl(4'h1, 4'h0);
    cpu(16'hF000, ERASED_BYTE);
    cpu(16'hD020, ERASED_BYTE);
    cpu(16'hE020, ERASED_BYTE);
    $display("test protection done");
  endtask
  task automatic t_link();
    toolInserted <= 1'b0;
    toolAttached <= 1'b1;
    pgm(1'b0);
    waitlvl(4'h2, 4'h2);
    tool.send_byte(LINK_ENTER);
    waitlvl(4'hC, 4'hC);
    chk(32'h1, {31'h0, icTest});
    pgm(1'b1);
    op(16'hF000, 8'h0F, 8'h01, 1'b1);
    cpu(16'hF000, 8'h0F);
    tool.send_byte(LINK_EXIT);
    waitlvl(4'hE, 4'h2);
    chk(32'h0, {31'h0, icTest});
    pgm(1'b0);
    $display("test link session done");
  endtask
  // Reset is held by the bench only at start, never during a session
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_app();
    t_tool();
    t_prot();
    t_link();
    conclude();
  end
  // Watchdog at 40000 clock cycles, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    failures++;
    conclude();
  end
endmodule
